//--- dual_mode_eeprom_port.v
// serial port logic of a 128 byte eeprom: transmit-only mode and i2c slave mode
// assumes pins sda/scl/transmit_only_clock are asynchronous, a cell array
// outside answers mem_rd_addr_o combinationally and accepts writes by handshake
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_port_consts.vh"

// Summary of operation
// - select byte msb first: type in 7..4, 3..1 ignored, bit 0 read.
// - sequential read returns consecutive bytes for as long as master acks.
// - after power-up the port starts in transmit-only mode.
// - first nine transmit-only clock pulses synchronise; sda stays released.
// - tenth pulse rising edge drives msb of byte at address 00h.
// - each byte takes nine pulses: eight bits msb first, one spare slot.
// - while scl high, bytes stream out with address advance.
// - after last location the address wraps to 00h.
// - falling scl moves the port into i2c mode.
// - in i2c mode writes execute only while transmit-only clock is high.
// - slave only; acknowledges after select byte of eight bits.
// - each received write byte is acknowledged in the ninth bit time while the write buffer has room.
// - during power-on reset every operation is disabled.
// - start is sda falling while scl high, before every command.
// - outside a write cycle, watch for start and stay silent until one.
// - stop is sda rising while scl high and ends communication.
// - stop after a read returns to standby.
// - stop after a write starts the internal write cycle; here only if a data byte was stored, so not after an inhibited write.
// - transmitter releases sda after eight bits; receiver pulls low on ninth.
// - sda is open drain: pulled low or released only.
// - once in i2c mode, never back to transmit-only mode.
// - page write increments only the three low address bits.
// - inhibited writes still acknowledge data but leave memory unchanged.
// - select byte is not acknowledged during the write cycle.
module dual_mode_eeprom_port #(
   parameter [3:0]  DEVICE_TYPE  = 4'h5,   // arbitrary value
   parameter [17:0] WRITE_CYCLES = `WRITE_CYCLES
) (
   // clock and power-on reset
   input  wire                 mclk_i,
   input  wire                 rst_i,
   // serial pins
   input  wire                 scl_i,
   input  wire                 sda_i,
   output reg                  sda_o,
   output reg                  sda_oe_o,
   input  wire                 transmit_only_clock_i,
   // cell array read port
   output reg  [`ADDR_W-1:0]   mem_rd_addr_o,
   input  wire [`DATA_W-1:0]   mem_rd_data_i,
   // cell array write port
   output reg                  mem_wr_valid_o,
   input  wire                 mem_wr_ready_i,
   output reg  [`ADDR_W-1:0]   mem_wr_addr_o,
   output reg  [`DATA_W-1:0]   mem_wr_data_o,
   // status
   output reg                  i2c_mode_o,
   output reg                  write_busy_o
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_ACK  = 3'h2;
   localparam [2:0] ST_TX   = 3'h3;
   localparam [2:0] ST_MACK = 3'h4;

   localparam [1:0] K_SEL  = 2'h0;
   localparam [1:0] K_ADDR = 2'h1;
   localparam [1:0] K_DATA = 2'h2;

   // pin synchronisers and edge history
   reg [2:0] scl_s;
   reg [2:0] sda_s;
   reg [2:0] toc_s;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         toc_s <= 3'h0;
      end else begin
         scl_s <= {scl_s[1:0], scl_i};
         sda_s <= {sda_s[1:0], sda_i};
         toc_s <= {toc_s[1:0], transmit_only_clock_i};
      end
   end

   wire scl      = scl_s[1];
   wire sda      = sda_s[1];
   wire wr_en    = toc_s[1];
   wire scl_rise = scl_s[1] && !scl_s[2];
   wire scl_fall = !scl_s[1] && scl_s[2];
   wire toc_rise = toc_s[1] && !toc_s[2];
   wire start_ev = scl && scl_s[2] && !sda && sda_s[2];
   wire stop_ev  = scl && scl_s[2] && sda && !sda_s[2];

   function [`ADDR_W-1:0] page_inc;
      input [`ADDR_W-1:0] a;
      begin
         page_inc = {a[`ADDR_W-1:`PAGE_BITS], a[`PAGE_BITS-1:0] + 1'b1};
      end
   endfunction

   // protocol state
   reg [2:0]          state;
   reg [1:0]          kind;
   reg [3:0]          bitcnt;
   reg [7:0]          shreg;
   reg                rd_cmd;
   reg                wr_pending;
   reg [3:0]          init_cnt;
   reg [3:0]          slot;
   reg [17:0]         wtimer;
   reg                acking;

   // write buffer
   wire               buf_in_ready;
   wire               buf_out_valid;
   wire [`WBUF_WIDTH-1:0] buf_out_data;
   reg                buf_push;
   reg  [`WBUF_WIDTH-1:0] buf_in_data;
   wire               buf_pop = write_busy_o && (!mem_wr_valid_o || mem_wr_ready_i);

   wr_fifo #(
      .WIDTH (`WBUF_WIDTH),
      .DEPTH (`WBUF_DEPTH)
   ) u_wbuf (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_valid_i  (buf_push),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (buf_in_data),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_pop),
      .out_data_o  (buf_out_data)
   );

   // write cycle: drain buffer to cells while the write time counts down
   always @(posedge mclk_i) begin
      if (rst_i) begin
         mem_wr_valid_o <= 1'b0;
         mem_wr_addr_o  <= {`ADDR_W{1'b0}};
         mem_wr_data_o  <= {`DATA_W{1'b0}};
      end else if (buf_pop && buf_out_valid) begin
         mem_wr_valid_o <= 1'b1;
         mem_wr_addr_o  <= buf_out_data[`WBUF_WIDTH-1:`DATA_W];
         mem_wr_data_o  <= buf_out_data[`DATA_W-1:0];
      end else if (mem_wr_ready_i) begin
         mem_wr_valid_o <= 1'b0;
      end
   end

   // main sequencer
   always @(posedge mclk_i) begin
      if (rst_i) begin
         i2c_mode_o    <= 1'b0;
         write_busy_o  <= 1'b0;
         sda_o         <= 1'b0;
         sda_oe_o      <= 1'b0;
         mem_rd_addr_o <= {`ADDR_W{1'b0}};
         state         <= ST_IDLE;
         kind          <= K_SEL;
         bitcnt        <= 4'h0;
         shreg         <= 8'h00;
         rd_cmd        <= 1'b0;
         wr_pending    <= 1'b0;
         init_cnt      <= 4'h0;
         slot          <= 4'h0;
         wtimer        <= 18'h00000;
         acking        <= 1'b0;
         buf_push      <= 1'b0;
         buf_in_data   <= {`WBUF_WIDTH{1'b0}};
      end else begin
         buf_push <= 1'b0;
         // only ever pull low or release
         sda_o    <= 1'b0;
         if (!i2c_mode_o) begin
            if (scl_fall) begin
               // mode flag is only ever set
               i2c_mode_o <= 1'b1;
               sda_oe_o   <= 1'b0;
            end else if (toc_rise && scl) begin
               if (init_cnt != `INIT_PULSES) begin
                  init_cnt <= init_cnt + 1'b1;
                  sda_oe_o <= 1'b0;
               // eight data slots then one spare
               end else if (slot == 4'h0) begin
                  // first byte shown is at the current address, 00h
                  sda_oe_o <= ~mem_rd_data_i[7];
                  shreg    <= {mem_rd_data_i[6:0], 1'b0};
                  // seven bit counter wraps to 00h
                  mem_rd_addr_o <= mem_rd_addr_o + 1'b1;
                  slot     <= 4'h1;
               end else if (slot == `LAST_DATA_SLOT) begin
                  sda_oe_o <= 1'b0;
                  slot     <= 4'h0;
               end else begin
                  sda_oe_o <= ~shreg[7];
                  shreg    <= {shreg[6:0], 1'b0};
                  slot     <= slot + 1'b1;
               end
            end
         end else if (write_busy_o) begin
            // bus ignored during the write cycle
            // so no select byte is acknowledged
            sda_oe_o <= 1'b0;
            state    <= ST_IDLE;
            if (wtimer != 18'h00000)
               wtimer <= wtimer - 1'b1;
            else if (!buf_out_valid && !mem_wr_valid_o)
               write_busy_o <= 1'b0;
         end else if (start_ev) begin
            // every transfer begins with the master's start
            sda_oe_o <= 1'b0;
            state    <= ST_RX;
            kind     <= K_SEL;
            bitcnt   <= 4'h0;
         end else if (stop_ev) begin
            sda_oe_o <= 1'b0;
            state    <= ST_IDLE;
            // stop after write data starts the cycle
            if (wr_pending) begin
               write_busy_o <= 1'b1;
               wtimer       <= WRITE_CYCLES;
               wr_pending   <= 1'b0;
            end
            // stop after a read is plain standby
         end else begin
            case (state)
               ST_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               ST_RX: begin
                  if (scl_rise && bitcnt != 4'h8) begin
                     shreg  <= {shreg[6:0], sda};
                     bitcnt <= bitcnt + 1'b1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     acking <= 1'b1;
                     state  <= ST_ACK;
                     case (kind)
                        K_SEL: begin
                           if (shreg[`SEL_TYPE_HI:`SEL_TYPE_LO] == DEVICE_TYPE) begin
                              sda_oe_o <= 1'b1;
                              rd_cmd   <= shreg[`SEL_RW_BIT];
                           end else begin
                              acking <= 1'b0;
                              state  <= ST_IDLE;
                           end
                        end
                        K_ADDR: begin
                           // byte address loads the shared counter
                           sda_oe_o      <= 1'b1;
                           mem_rd_addr_o <= shreg[`ADDR_W-1:0];
                        end
                        default: begin
                           if (!wr_en) begin
                              sda_oe_o <= 1'b1;
                           end else if (buf_in_ready) begin
                              // store only while write enable high
                              sda_oe_o    <= 1'b1;
                              buf_push    <= 1'b1;
                              buf_in_data <= {mem_rd_addr_o, shreg};
                              wr_pending  <= 1'b1;
                           end else begin
                              acking <= 1'b0;
                              state  <= ST_IDLE;
                           end
                           // page wrap on the low address bits
                           mem_rd_addr_o <= page_inc(mem_rd_addr_o);
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  // ack held through the ninth clock
                  if (scl_fall && acking) begin
                     acking <= 1'b0;
                     bitcnt <= 4'h0;
                     if (kind == K_SEL && rd_cmd) begin
                        // first read byte from the current address
                        sda_oe_o      <= ~mem_rd_data_i[7];
                        shreg         <= {mem_rd_data_i[6:0], 1'b0};
                        mem_rd_addr_o <= mem_rd_addr_o + 1'b1;
                        state         <= ST_TX;
                     end else begin
                        sda_oe_o <= 1'b0;
                        kind     <= (kind == K_SEL) ? K_ADDR : K_DATA;
                        state    <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 1'b1;
                  end else if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        sda_oe_o <= 1'b0;
                        state    <= ST_MACK;
                     end else begin
                        sda_oe_o <= ~shreg[7];
                        shreg    <= {shreg[6:0], 1'b0};
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     // master ack sampled in ninth slot
                     if (sda)
                        state <= ST_IDLE;
                     else
                        bitcnt <= 4'h0;
                  end else if (scl_fall && bitcnt == 4'h0) begin
                     sda_oe_o      <= ~mem_rd_data_i[7];
                     shreg         <= {mem_rd_data_i[6:0], 1'b0};
                     mem_rd_addr_o <= mem_rd_addr_o + 1'b1;
                     state         <= ST_TX;
                  end
               end
               default: begin
                  sda_oe_o <= 1'b0;
                  state    <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule // dual_mode_eeprom_port

`default_nettype wire

//--- eeprom_port_consts.vh
// constants for the dual mode serial eeprom port
// assumes a 25 MHz system clock; included by its bare name
`ifndef EEPROM_PORT_CONSTS_VH
`define EEPROM_PORT_CONSTS_VH

// clock and write cycle timing
`define CLK_PERIOD_NS    40
`define WRITE_TIME_NS    10000000
`define WRITE_CYCLES     18'd250000

// memory geometry
`define ADDR_W           7
`define DATA_W           8
`define PAGE_BITS        3

// transmit-only sequencing
`define INIT_PULSES      4'h9
`define BYTE_SLOTS       4'h9
`define LAST_DATA_SLOT   4'h8

// select byte layout
`define SEL_TYPE_HI      7
`define SEL_TYPE_LO      4
`define SEL_RW_BIT       0

// write buffer
`define WBUF_WIDTH       15
`define WBUF_DEPTH       32

`endif

//--- wr_fifo.v
// flip-flop fifo with valid/ready on both sides
// single clock, synchronous active high reset
`timescale 1ns/1ns
`default_nettype none

module wr_fifo #(
   parameter WIDTH = 15,
   parameter DEPTH = 32
) (
   // clock and reset
   input  wire             mclk_i,
   input  wire             rst_i,
   // fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   function integer clog2;
      input integer v;
      integer n;
      begin
         n = 0;
         while ((1 << n) < v)
            n = n + 1;
         clog2 = (n < 1) ? 1 : n;
      end
   endfunction

   localparam AW = clog2(DEPTH);

   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;

   wire push = in_valid_i && in_ready_o;
   wire pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = store[rd_ptr];

   always @(posedge mclk_i) begin
      if (push)
         store[wr_ptr] <= in_data_i;
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

endmodule // wr_fifo

`default_nettype wire

//--- eeprom_port_monitor.sv
// assertions on the top-level ports of the dual mode eeprom port
// assumes a single clock domain and the synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_monitor (
   // clock and reset
   input wire logic       mclk_i,
   input wire logic       rst_i,
   // serial pins
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       transmit_only_clock_i,
   // cell array
   input wire logic [6:0] mem_rd_addr_o,
   input wire logic [7:0] mem_rd_data_i,
   input wire logic       mem_wr_valid_o,
   input wire logic       mem_wr_ready_i,
   input wire logic [6:0] mem_wr_addr_o,
   input wire logic [7:0] mem_wr_data_o,
   // status
   input wire logic       i2c_mode_o,
   input wire logic       write_busy_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   reset_state_a: assert property (
      $fell(rst_i) |-> !i2c_mode_o && !sda_oe_o && !write_busy_o && mem_rd_addr_o == 7'h00)
      else $error("port not idle after reset");
   open_drain_a: assert property (sda_o == 1'b0)
      else $error("sda driven high");
   mode_sticky_a: assert property ($past(i2c_mode_o) |-> i2c_mode_o)
      else $error("left i2c mode");
   mode_switch_a: assert property ($fell(scl_i) |-> ##[1:6] i2c_mode_o)
      else $error("no switch to i2c mode");
   busy_silent_a: assert property (write_busy_o |-> !sda_oe_o)
      else $error("sda pulled during write cycle");
   write_in_cycle_a: assert property (mem_wr_valid_o |-> write_busy_o)
      else $error("cell write outside write cycle");
   write_hold_a: assert property (
      mem_wr_valid_o && !mem_wr_ready_i |=>
         mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
      else $error("write request dropped or changed");
   tx_bit_time_a: assert property (
      !i2c_mode_o && $rose(sda_oe_o) |-> $past(transmit_only_clock_i, 2))
      else $error("bit driven without clock pulse");
   tx_addr_step_a: assert property (
      !i2c_mode_o && !$past(i2c_mode_o) && mem_rd_addr_o != $past(mem_rd_addr_o) |->
         mem_rd_addr_o == $past(mem_rd_addr_o) + 7'h01)
      else $error("address did not step by one");
endmodule // eeprom_port_monitor
`default_nettype wire

//--- serial_host_model.sv
// bus master model: drives scl, pulls sda low, makes the transmit-only clock
// assumes the caller enters each task just after a falling mclk edge
`timescale 1ns/1ns
`default_nettype none
module serial_host_model #(
   parameter QUARTER = 10
) (
   // clock and wire level
   input  wire logic mclk_i,
   input  wire logic sda_i,
   // driven pins
   output var logic  scl_o,
   output var logic  sda_low_o,
   output var logic  toc_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
      toc_o = 1'b0;
   end
   task automatic wait_q;
      repeat (QUARTER) @(negedge mclk_i);
   endtask
   task automatic toc_pulse;
      toc_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      toc_o = 1'b0;
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic set_toc(input logic v);
      toc_o = v;
   endtask
   task automatic mode_switch;
      scl_o = 1'b0;
      wait_q();
      scl_o = 1'b1;
      wait_q();
   endtask
   task automatic start;
      sda_low_o = 1'b0;
      wait_q();
      scl_o = 1'b1;
      wait_q();
      sda_low_o = 1'b1;
      wait_q();
      scl_o = 1'b0;
      wait_q();
   endtask
   task automatic stop;
      sda_low_o = 1'b1;
      wait_q();
      scl_o = 1'b1;
      wait_q();
      sda_low_o = 1'b0;
      wait_q();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = ~b;
      wait_q();
      scl_o = 1'b1;
      wait_q();
      r = sda_i;
      wait_q();
      scl_o = 1'b0;
      wait_q();
   endtask
   task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] q,
                          output logic r9);
      int i;
      for (i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(b9, r9);
   endtask
endmodule // serial_host_model
`default_nettype wire

//--- dual_mode_eeprom_port_tb.sv
// self-checking bench for the dual mode eeprom port
// assumes the host model for the pins and a cell array model held here
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
   begin \
      checks_done++; \
      if ((a) !== (e)) begin \
         errors++; \
         $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); \
      end \
   end
module dual_mode_eeprom_port_tb;
   localparam [3:0] DEV = 4'h9; // arbitrary type code
   logic       mclk;
   logic       rst;
   logic       scl;
   logic       host_low;
   logic       toc;
   logic       sda_oe;
   logic       sda_drv;
   logic       sda;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic       wr_valid;
   logic       wr_ready = 1'b0;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic       i2c_mode;
   logic       write_busy;
   logic [7:0] mem [0:127];
   int         errors;
   int         checks_done;
   int         cycles;
   assign sda = ~(sda_oe | host_low);
   assign rd_data = mem[rd_addr];
   serial_host_model u_serial_host_model (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
      .sda_low_o(host_low), .toc_o(toc));
   dual_mode_eeprom_port #(.DEVICE_TYPE(DEV), .WRITE_CYCLES(18'd1000)) u_dual_mode_eeprom_port (
      .mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
      .sda_oe_o(sda_oe), .transmit_only_clock_i(toc), .mem_rd_addr_o(rd_addr),
      .mem_rd_data_i(rd_data), .mem_wr_valid_o(wr_valid), .mem_wr_ready_i(wr_ready),
      .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .i2c_mode_o(i2c_mode),
      .write_busy_o(write_busy));
   function automatic logic [7:0] init_val(input int i);
      return 8'(i * 37 + 5);
   endfunction
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // cell array: writes accepted on handshake, stalls every other cycle
   always @(posedge mclk) begin
      if (wr_valid && wr_ready) begin
         mem[wr_addr] <= wr_data;
      end
   end
   always @(negedge mclk) begin
      wr_ready <= ~wr_ready;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test;
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic t_transmit_only;
      int i;
      int b;
      for (i = 0; i < 9; i++) begin
         u_serial_host_model.toc_pulse();
         `CHK(sda_oe, 1'b0)
      end
      for (i = 0; i < 129; i++) begin
         for (b = 7; b >= 0; b--) begin
            u_serial_host_model.toc_pulse();
            `CHK(sda_oe, ~mem[i % 128][b])
         end
         u_serial_host_model.toc_pulse();
         `CHK(sda_oe, 1'b0)
      end
      `CHK(rd_addr, 7'h01)
   endtask
   task automatic t_mode_switch;
      u_serial_host_model.mode_switch();
      `CHK(i2c_mode, 1'b1)
      `CHK(sda_oe, 1'b0)
      `CHK(sda_drv, 1'b0)
      u_serial_host_model.toc_pulse();
      `CHK(i2c_mode, 1'b1)
   endtask
   // write with the enable pin low: acked, nothing stored
   task automatic t_inhibited_write;
      logic [7:0] q;
      logic       r;
      u_serial_host_model.set_toc(1'b0);
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b101, 1'b0}, 1'b1, q, r);
      `CHK(r, 1'b0)
      u_serial_host_model.byte_io(8'h10, 1'b1, q, r);
      `CHK(r, 1'b0)
      u_serial_host_model.byte_io(8'h5a, 1'b1, q, r);
      `CHK(r, 1'b0)
      u_serial_host_model.stop();
      repeat (40) @(negedge mclk);
      `CHK(write_busy, 1'b0)
      `CHK(mem[16], init_val(16))
   endtask
   // page write across the page end, then polling while busy
   task automatic t_page_write;
      logic [7:0] q;
      logic       r;
      int         i;
      u_serial_host_model.set_toc(1'b1);
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b010, 1'b0}, 1'b1, q, r);
      u_serial_host_model.byte_io(8'h7e, 1'b1, q, r);
      for (i = 0; i < 3; i++) begin
         u_serial_host_model.byte_io(8'hc0 + 8'(i), 1'b1, q, r);
         `CHK(r, 1'b0)
      end
      u_serial_host_model.stop();
      `CHK(write_busy, 1'b1)
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b010, 1'b0}, 1'b1, q, r);
      `CHK(r, 1'b1)
      u_serial_host_model.stop();
      for (i = 0; i < 3000 && write_busy !== 1'b0; i++) begin
         @(negedge mclk);
      end
      `CHK(write_busy, 1'b0)
      `CHK(mem[126], 8'hc0)
      `CHK(mem[127], 8'hc1)
      `CHK(mem[120], 8'hc2)
   endtask
   task automatic t_read;
      logic [7:0] q;
      logic       r;
      u_serial_host_model.start();
      u_serial_host_model.byte_io({~DEV, 3'b000, 1'b1}, 1'b1, q, r);
      `CHK(r, 1'b1)
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b111, 1'b0}, 1'b1, q, r);
      u_serial_host_model.byte_io(8'h7e, 1'b1, q, r);
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b000, 1'b1}, 1'b1, q, r);
      `CHK(r, 1'b0)
      u_serial_host_model.byte_io(8'hff, 1'b0, q, r);
      `CHK(q, 8'hc0)
      u_serial_host_model.byte_io(8'hff, 1'b0, q, r);
      `CHK(q, 8'hc1)
      u_serial_host_model.byte_io(8'hff, 1'b1, q, r);
      `CHK(q, init_val(0))
      u_serial_host_model.stop();
      u_serial_host_model.start();
      u_serial_host_model.byte_io({DEV, 3'b011, 1'b1}, 1'b1, q, r);
      u_serial_host_model.byte_io(8'hff, 1'b1, q, r);
      `CHK(q, init_val(1))
      u_serial_host_model.stop();
   endtask
   initial begin
      errors = 0;
      checks_done = 0;
      rst = 1'b1;
      for (int i = 0; i < 128; i++) begin
         mem[i] = init_val(i);
      end
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK(i2c_mode, 1'b0)
      t_transmit_only();
      t_mode_switch();
      t_inhibited_write();
      t_page_write();
      t_read();
      finish_test();
   end
endmodule // dual_mode_eeprom_port_tb
bind dual_mode_eeprom_port eeprom_port_monitor u_eeprom_port_monitor (
   .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .transmit_only_clock_i(transmit_only_clock_i),
   .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_data_i(mem_rd_data_i),
   .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
   .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
   .i2c_mode_o(i2c_mode_o), .write_busy_o(write_busy_o));
`default_nettype wire
